// File: hw/i2p_pkg.sv
// Constants for the two-wire register access port of a four-rail regulator.
// Assumes one system clock of 50 MHz and a bus clock supplied by the master.
package i2p_pkg;

	// ----------------------------------------
	// Bus identity and sizes
	// ----------------------------------------
	localparam logic [6:0] DEV_ADDR   = 7'h60;
	localparam int         NREG       = 24;
	localparam logic [3:0] BITS_DATA  = 4'h8;
	localparam logic [3:0] BITS_ACK   = 4'h9;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_FUSE_REVISION_ID     = 8'h01;
	localparam logic [7:0] OFS_RAIL0_ENABLE_CONTROL = 8'h02;
	localparam logic [7:0] OFS_RAIL0_LIMIT_SLEW     = 8'h03;
	localparam logic [7:0] OFS_RAIL1_ENABLE_CONTROL = 8'h04;
	localparam logic [7:0] OFS_RAIL1_LIMIT_SLEW     = 8'h05;
	localparam logic [7:0] OFS_RAIL2_ENABLE_CONTROL = 8'h06;
	localparam logic [7:0] OFS_RAIL2_LIMIT_SLEW     = 8'h07;
	localparam logic [7:0] OFS_RAIL3_ENABLE_CONTROL = 8'h08;
	localparam logic [7:0] OFS_RAIL3_LIMIT_SLEW     = 8'h09;
	localparam logic [7:0] OFS_RAIL0_VOLTAGE_SET    = 8'h0a;
	localparam logic [7:0] OFS_RAIL0_FLOOR_VOLTAGE  = 8'h0b;
	localparam logic [7:0] OFS_RAIL1_VOLTAGE_SET    = 8'h0c;
	localparam logic [7:0] OFS_RAIL1_FLOOR_VOLTAGE  = 8'h0d;
	localparam logic [7:0] OFS_RAIL2_VOLTAGE_SET    = 8'h0e;
	localparam logic [7:0] OFS_RAIL2_FLOOR_VOLTAGE  = 8'h0f;
	localparam logic [7:0] OFS_RAIL3_VOLTAGE_SET    = 8'h10;
	localparam logic [7:0] OFS_RAIL3_FLOOR_VOLTAGE  = 8'h11;
	localparam logic [7:0] OFS_RAIL0_SEQUENCE_DELAY = 8'h12;
	localparam logic [7:0] OFS_RAIL1_SEQUENCE_DELAY = 8'h13;
	localparam logic [7:0] OFS_RAIL2_SEQUENCE_DELAY = 8'h14;
	localparam logic [7:0] OFS_RAIL3_SEQUENCE_DELAY = 8'h15;
	localparam logic [7:0] OFS_SOFT_RESET_CONTROL   = 8'h16;
	localparam logic [7:0] OFS_DEVICE_CONFIG        = 8'h17;
	localparam logic [7:0] OFS_TOP_INTERRUPT_FLAGS  = 8'h18;

	// ----------------------------------------
	// Reset values and fuse-backed bits, offsets 0x01 upward
	// ----------------------------------------
	localparam logic [7:0] RST_VAL [1:NREG] = '{
		8'h00, 8'hc8, 8'h12, 8'hc8, 8'h12, 8'hc8, 8'h12, 8'hc8,
		8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] FUSE_MASK [1:NREG] = '{
		8'hff, 8'he2, 8'h3f, 8'he2, 8'h3f, 8'he2, 8'h3f, 8'he2,
		8'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// ----------------------------------------
	// Protocol states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_IDX  = 3'b010,
		ST_WR   = 3'b011,
		ST_RD   = 3'b100,
		ST_SKIP = 3'b101
	} i2p_state_t;

endpackage

// File: hw/i2p_port.sv
// Two-wire slave port with the 24-register control map.
// Assumes open-drain bus lines resolved outside; scl also clocks the capture flop.

// ----------------------------------------
// Pin filter: three stages, change taken once stages two and three agree
// ----------------------------------------
module i2p_pin_sync
	import i2p_pkg::*;
#(
	parameter logic INIT = 1'b1
)(
	input  wire logic clk,    // System clock
	input  wire logic srst,   // Sync reset
	input  wire logic pin,    // Raw pin
	output logic      filt_q  // Filtered level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s1_q   <= INIT;
			s2_q   <= INIT;
			s3_q   <= INIT;
			filt_q <= INIT;
		end
		else
		begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				filt_q <= s3_q;
		end
	end
endmodule // i2p_pin_sync

// What this block does
// - Answer only at seven-bit address 0x60.
// - Direction zero means write, one means read.
// - Byte after the address byte loads the register index.
// - Next byte is stored into the indexed register, except at read-only offset 0x01.
// - Index steps by one after each written data byte until STOP.
// - Reads never advance the index.
// - Fuse-backed bits load from fuse memory during the fuse-loading state.
// - Pull data low on the ninth clock of each received byte.
// - Never drive data once the filtered chip reset pin level is low.
module i2p_port
	import i2p_pkg::*;
#(
	parameter logic [7:0] FUSE_REV_ID = 8'h5a // Arbitrary value
)(
	input  wire logic                 clk,                   // System clock
	input  wire logic                 srst,                  // Sync reset
	input  wire logic                 scl,                   // Bus clock, link domain
	input  wire logic                 sda_i,                 // Data line level
	output logic                      sda_o,                 // Data drive value
	output logic                      sda_oe,                // Data drive enable
	input  wire logic                 chip_reset_pin_low_n,  // Chip reset pin
	input  wire logic                 fuse_load,             // Fuse-loading state
	input  wire logic [7:0]           fuse_addr,             // Fuse target offset
	input  wire logic [7:0]           fuse_data,             // Fuse word
	output logic [NREG:1][7:0]        reg_image              // All registers
);

	// ----------------------------------------
	// Link domain capture and crossing
	// ----------------------------------------
	logic link_bit_q;
	logic rx_s1_q;
	logic rx_s2_q;
	logic rx_s3_q;

	// Held from one scl rise to the next; the three-stage crossing
	// settles well before the filtered rise consumes it
	always_ff @(posedge scl)
		link_bit_q <= sda_i;

	always_ff @(posedge clk)
	begin
		rx_s1_q <= link_bit_q;
		rx_s2_q <= rx_s1_q;
		rx_s3_q <= rx_s2_q;
	end

	// ----------------------------------------
	// Pin filtering and bus events
	// ----------------------------------------
	logic scl_f;
	logic sda_f;
	logic chip_reset_pin_low_f;
	logic scl_prev_q;
	logic sda_prev_q;

	i2p_pin_sync #(.INIT(1'b1)) u_scl (
		.clk    (clk),
		.srst   (srst),
		.pin    (scl),
		.filt_q (scl_f)
	);
	i2p_pin_sync #(.INIT(1'b1)) u_sda (
		.clk    (clk),
		.srst   (srst),
		.pin    (sda_i),
		.filt_q (sda_f)
	);
	i2p_pin_sync #(.INIT(1'b0)) u_chip_reset_pin_low (
		.clk    (clk),
		.srst   (srst),
		.pin    (chip_reset_pin_low_n),
		.filt_q (chip_reset_pin_low_f)
	);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			scl_prev_q <= scl_f;
			sda_prev_q <= sda_f;
		end
	end

	wire rise_w  = scl_f & ~scl_prev_q;
	wire fall_w  = ~scl_f & scl_prev_q;
	wire start_w = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
	wire stop_w  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

	// ----------------------------------------
	// Protocol engine
	// ----------------------------------------
	i2p_state_t       st_q;
	i2p_state_t       st_d;
	logic       [3:0] bit_q;
	logic       [3:0] bit_d;
	logic       [7:0] sh_q;
	logic       [7:0] sh_d;
	logic       [7:0] tx_q;
	logic       [7:0] tx_d;
	logic       [7:0] idx_q;
	logic       [7:0] idx_d;
	logic             oe_q;
	logic             oe_d;
	logic             sda_lo_q;
	logic [NREG:1][7:0] regs_q;

	wire       byte_end_w = fall_w & (bit_q == BITS_DATA);
	wire       ack_end_w  = fall_w & (bit_q == BITS_ACK);
	wire       addr_hit_w = (sh_q[7:1] == DEV_ADDR);
	wire       in_rng_w   = (idx_q >= OFS_FUSE_REVISION_ID) &&
	                        (idx_q <= OFS_TOP_INTERRUPT_FLAGS);
	wire [7:0] rdata_w    = in_rng_w ? regs_q[idx_q[4:0]] : 8'h00;
	wire       wr_stb_w   = byte_end_w & (st_q == ST_WR);
	wire       active_w   = (st_q != ST_IDLE) && (st_q != ST_SKIP);

	always_comb
	begin
		st_d  = st_q;
		bit_d = bit_q;
		sh_d  = sh_q;
		tx_d  = tx_q;
		idx_d = idx_q;
		oe_d  = oe_q;
		if (stop_w)
		begin
			st_d = ST_IDLE;
			oe_d = 1'b0;
		end
		else if (start_w)
		begin
			// Repeated start behaves as a fresh start, index kept
			st_d  = ST_ADDR;
			bit_d = 4'h0;
			oe_d  = 1'b0;
		end
		else if (rise_w && active_w)
		begin
			if (bit_q < BITS_DATA)
				sh_d = {sh_q[6:0], rx_s3_q};
			else if (st_q == ST_RD && rx_s3_q)
				st_d = ST_SKIP; // Master ended the read
			bit_d = bit_q + 4'h1;
		end
		else if (byte_end_w && active_w)
		begin
			oe_d = 1'b0;
			unique case (st_q)
				ST_ADDR:
				begin
					if (addr_hit_w)
					begin
						oe_d = 1'b1;
						st_d = sh_q[0] ? ST_RD : ST_IDX;
					end
					else
						st_d = ST_SKIP;
				end
				ST_IDX:
				begin
					oe_d  = 1'b1;
					idx_d = sh_q;
					st_d  = ST_WR;
				end
				ST_WR:
				begin
					oe_d  = 1'b1;
					idx_d = idx_q + 8'h01;
				end
				ST_RD:
					oe_d = 1'b0;
				ST_IDLE, ST_SKIP:
					oe_d = 1'b0;
			endcase
		end
		else if (ack_end_w && active_w)
		begin
			bit_d = 4'h0;
			oe_d  = 1'b0;
			if (st_q == ST_RD)
			begin
				// Same register each byte, index untouched
				oe_d = ~rdata_w[7];
				tx_d = {rdata_w[6:0], 1'b0};
			end
		end
		else if (fall_w && st_q == ST_RD)
		begin
			oe_d = ~tx_q[7];
			tx_d = {tx_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_q  <= ST_IDLE;
			bit_q <= 4'h0;
			sh_q  <= 8'h00;
			tx_q  <= 8'h00;
			idx_q <= 8'h00;
			sda_lo_q <= 1'b0;
			oe_q  <= 1'b0;
		end
		else
		begin
			st_q  <= st_d;
			bit_q <= bit_d;
			sh_q  <= sh_d;
			tx_q  <= tx_d;
			idx_q <= idx_d;
			sda_lo_q <= 1'b0;
			oe_q  <= oe_d & chip_reset_pin_low_f;
		end
	end

	// Open drain: the drive value never leaves low
	assign sda_o     = sda_lo_q;
	assign sda_oe    = oe_q;
	assign reg_image = regs_q;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Fuse loading wins over a bus write landing in the same cycle
	for (genvar g = 1; g <= NREG; g++)
	begin : g_reg
		localparam logic [7:0] OFS  = 8'(g);
		localparam logic [7:0] RVAL = (g == 1) ? FUSE_REV_ID : RST_VAL[g];
		wire fuse_hit = fuse_load && (fuse_addr == OFS);
		wire bus_hit  = wr_stb_w && (idx_q == OFS) && (OFS != OFS_FUSE_REVISION_ID);
		wire [7:0] fuse_mix = (regs_q[g] & ~FUSE_MASK[g]) | (fuse_data & FUSE_MASK[g]);

		always_ff @(posedge clk)
		begin
			if (srst)
				regs_q[g] <= RVAL;
			else if (fuse_hit)
				regs_q[g] <= fuse_mix;
			else if (bus_hit)
				regs_q[g] <= sh_q;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_addr_byte;
		byte_end_w && st_q == ST_ADDR;
	endsequence

	sequence s_data_byte;
		byte_end_w && (st_q == ST_IDX || st_q == ST_WR) && chip_reset_pin_low_f;
	endsequence

	property p_addr_match;
		s_addr_byte and (addr_hit_w && chip_reset_pin_low_f) |=> oe_q;
	endproperty
	a_addr_match: assert property (p_addr_match)
		else $error("own address not acknowledged");

	property p_direction;
		s_addr_byte and addr_hit_w |=>
			st_q == ($past(sh_q[0]) ? ST_RD : ST_IDX);
	endproperty
	a_direction: assert property (p_direction)
		else $error("direction bit decoded wrongly");

	property p_index_load;
		byte_end_w && st_q == ST_IDX |=> idx_q == $past(sh_q) && st_q == ST_WR;
	endproperty
	a_index_load: assert property (p_index_load)
		else $error("index byte not loaded");

	property p_store;
		wr_stb_w && in_rng_w && idx_q != OFS_FUSE_REVISION_ID && !fuse_load
			|=> regs_q[$past(idx_q[4:0])] == $past(sh_q);
	endproperty
	a_store: assert property (p_store)
		else $error("data byte not stored");

	property p_increment;
		wr_stb_w |=> idx_q == $past(idx_q) + 8'h01;
	endproperty
	a_increment: assert property (p_increment)
		else $error("index did not step after write");

	property p_read_hold;
		st_q == ST_RD && !start_w |=> $stable(idx_q);
	endproperty
	a_read_hold: assert property (p_read_hold)
		else $error("index moved during read");

	property p_fuse;
		fuse_load && fuse_addr >= OFS_FUSE_REVISION_ID &&
		fuse_addr <= OFS_TOP_INTERRUPT_FLAGS |=>
			(regs_q[$past(fuse_addr[4:0])] & FUSE_MASK[$past(fuse_addr[4:0])]) ==
			($past(fuse_data) & FUSE_MASK[$past(fuse_addr[4:0])]);
	endproperty
	a_fuse: assert property (p_fuse)
		else $error("fuse bits not loaded");

	property p_ack_hold;
		s_data_byte |=> oe_q [*2];
	endproperty
	a_ack_hold: assert property (p_ack_hold)
		else $error("acknowledge not driven");

	property p_reset_pin;
		// Five low samples flush the pin filter and the drive flop
		!chip_reset_pin_low_n [*5] |=> !oe_q;
	endproperty
	a_reset_pin: assert property (p_reset_pin)
		else $error("data driven while chip reset low");

	property p_foreign;
		s_addr_byte and !addr_hit_w |=> !oe_q && st_q == ST_SKIP;
	endproperty
	a_foreign: assert property (p_foreign)
		else $error("foreign address acknowledged");

endmodule // i2p_port

// File: tb/i2p_host.sv
// Two-wire bus master model for the register port bench.
// Assumes a pull-up on the data line; the bench resolves the wire.
module i2p_host (
	input  wire logic       sda,     // Resolved data line
	output logic            scl,     // Bus clock, 160 ns period
	output logic            pull,    // Pulls data low
	output logic [8:0]      res,     // Ack flag and byte
	output logic            res_stb  // Result strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int H = 80;

	initial
	begin
		scl = 1'b1;
		pull = 1'b0;
		res = '0;
		res_stb = 1'b0;
	end

	// ----------------------------------------
	// Nine clocks, MSB first; data moves 20 ns after the fall
	// ----------------------------------------
	task automatic xfer(input logic [8:0] b, input logic rd);
		logic [8:0] r;
		for (int i = 8; i >= 0; i--)
		begin
			// Long low phase covers the port's pin filter lag
			#20 pull = !b[i];
			#(H + 20) scl = 1'b1;
			#(H - 50) r[i] = sda;
			#10 scl = 1'b0;
		end
		#20 pull = 1'b0;
		res = rd ? {1'b0, r[8:1]} : {!r[0], 8'h00};
		res_stb = 1'b1;
		#1 res_stb = 1'b0;
	endtask

	// Clock stands high between frames
	task automatic start;
		#(H + 40) scl = 1'b1;
		#H pull = 1'b1;
		#H scl = 1'b0;
	endtask

	task automatic stop;
		pull = 1'b1;
		#H scl = 1'b1;
		#H pull = 1'b0;
		#H;
	endtask
endmodule // i2p_host

// File: tb/tb_i2c_register_access_port.sv
// Self-checking bench for the two-wire register port.
// Assumes the master model in i2p_host and a pull-up on the data line.
module tb_i2c_register_access_port
	import i2p_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic              chip_reset_pin_low_n = 1'b1;
	logic              fuse_load = 1'b0;
	logic [7:0]        fuse_addr = '0;
	logic [7:0]        fuse_data = '0;
	logic              scl, pull, stb, sda_o, sda_oe;
	wire               sda;
	logic [8:0]        res;
	logic [NREG:1][7:0] img;
	logic [8:0]        q[$];
	logic [7:0]        w[1:25];
	int                n_fail = 0;
	int                check_count = 0;
	int                seed = 32'h5b947baf;

	assign sda = !(pull || (sda_oe && !sda_o));
	always #10 clk = !clk;

	i2p_host h (.sda(sda), .scl(scl), .pull(pull), .res(res), .res_stb(stb));

	i2p_port #(.FUSE_REV_ID(8'h5a)) dut (
		.clk(clk), .srst(srst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .chip_reset_pin_low_n(chip_reset_pin_low_n),
		.fuse_load(fuse_load), .fuse_addr(fuse_addr), .fuse_data(fuse_data),
		.reg_image(img));

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic check(input logic [8:0] s, input logic [8:0] e);
		check_count++;
		if (s !== e)
		begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Empty queue means an unexpected result
	always @(posedge stb)
		check(res, q.size() ? q.pop_front() : 9'h1ff);

	task automatic tx(input logic [7:0] b, input logic a);
		q.push_back({a, 8'h00});
		h.xfer({b, 1'b1}, 1'b0);
	endtask

	// Three bytes from one index, last one refused by the master
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		h.start;
		tx({DEV_ADDR, 1'b0}, 1'b1);
		tx(i, 1'b1);
		h.start;
		tx({DEV_ADDR, 1'b1}, 1'b1);
		for (int k = 0; k < 3; k++)
		begin
			q.push_back({1'b0, e});
			h.xfer({8'hff, k == 2}, 1'b1);
		end
		h.stop;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		repeat (10) @(posedge clk);
		rd(8'h01, 8'h5a);
		rd(8'h02, 8'hc8);
		rd(8'h03, 8'h12);
		$display("reset values done");
		@(posedge clk);
		fuse_load <= 1'b1;
		fuse_addr <= 8'h02;
		fuse_data <= 8'h00;
		@(posedge clk);
		fuse_load <= 1'b0;
		@(posedge clk);
		#1 check({1'b0, img[2]}, 9'h008);
		check({8'h00, sda_o}, 9'h000);
		rd(8'h02, 8'h08);
		$display("fuse load done");
		// Burst runs over the read-only and unmapped places
		h.start;
		tx({DEV_ADDR, 1'b0}, 1'b1);
		tx(8'h01, 1'b1);
		for (int i = 1; i <= 25; i++)
		begin
			w[i] = 8'($random(seed));
			tx(w[i], 1'b1);
		end
		h.stop;
		for (int i = 2; i <= NREG; i++)
			check({1'b0, img[i]}, {1'b0, w[i]});
		for (int i = 1; i <= 25; i++)
			rd(8'(i), i == 1 ? 8'h5a : (i > 24 ? 8'h00 : w[i]));
		$display("auto increment done");
		h.start;
		tx({DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
		h.stop;
		@(posedge clk);
		chip_reset_pin_low_n <= 1'b0;
		repeat (10) @(posedge clk);
		h.start;
		tx({DEV_ADDR, 1'b0}, 1'b0);
		h.stop;
		@(posedge clk);
		chip_reset_pin_low_n <= 1'b1;
		repeat (10) @(posedge clk);
		rd(8'h18, w[24]);
		$display("address and chip reset done");
		stop_test;
	end

	initial
	begin
		#1000000;
		n_fail++;
		stop_test;
	end
endmodule // tb_i2c_register_access_port
